// file: sbtc_far_model.sv
// Far-side model: count clock sources and compare-module triggers.
`default_nettype none
module sbtc_far_model (
  input wire logic clk,
  output logic ext_clk,
  output logic osc_clk,
  output logic cmp1_trig,
  output logic cmp2_trig
);
  timeunit 1ns;
  timeprecision 1ps;
  // Sources idle low between bursts, nothing runs free
  initial begin
    ext_clk = 1'b0;
    osc_clk = 1'b0;
    cmp1_trig = 1'b0;
    cmp2_trig = 1'b0;
  end
  // Slow square wave, four core cycles high and five low, one rising edge per pulse
  task automatic pulses(input bit use_osc, input int n);
    repeat (n) begin
      @(posedge clk);
      osc_clk <= use_osc;
      ext_clk <= !use_osc;
      repeat (4) @(posedge clk);
      osc_clk <= 1'b0;
      ext_clk <= 1'b0;
      repeat (4) @(posedge clk);
    end
  endtask
  // One-cycle special-event trigger from compare module one or two
  task automatic fire(input int which);
    cmp1_trig <= (which == 1);
    cmp2_trig <= (which == 2);
    @(posedge clk);
    cmp1_trig <= 1'b0;
    cmp2_trig <= 1'b0;
  endtask
endmodule // sbtc_far_model
`default_nettype wire

// file: sbtc_pkg.sv
// Constants and types for the sixteen-bit timer/counter.
`default_nettype none
package sbtc_pkg;
  // ********************************************************************
  // Register map, one aligned word each
  // ********************************************************************
  localparam logic [7:0] SBTC_ADDR_CTRL = 8'h00;
  localparam logic [7:0] SBTC_ADDR_LOW = 8'h04;
  localparam logic [7:0] SBTC_ADDR_HIGH = 8'h08;
  localparam logic [7:0] SBTC_ADDR_FLAG = 8'h0C;
  localparam logic [7:0] SBTC_ADDR_IEN = 8'h10;
  localparam logic [7:0] SBTC_ADDR_OSC = 8'h14;
  localparam logic [7:0] SBTC_ADDR_CMP = 8'h18;
  localparam logic [7:0] SBTC_ADDR_PORT = 8'h1C;
  // ********************************************************************
  // Timer control fields
  // ********************************************************************
  localparam int SBTC_RUN_BIT = 0;
  localparam int SBTC_SRC_BIT = 1;
  localparam int SBTC_NSYNC_BIT = 2;
  localparam int SBTC_OSCEN_BIT = 3;
  localparam int SBTC_PS_LO = 4;
  localparam int SBTC_STATUS_BIT = 6;
  localparam int SBTC_WIDE_BIT = 7;
  localparam int SBTC_LP_BIT = 8;
  localparam int SBTC_IDLE_ENABLE_BIT_BIT = 7;
  localparam int SBTC_CMP2_LO = 4;
  localparam int SBTC_SLEEP_BIT = 8;
  localparam logic [1:0] SBTC_SCS_SEC = 2'h1;
  localparam logic [3:0] SBTC_CMP_SPECIAL = 4'hB;
  localparam logic [15:0] SBTC_COUNT_MAX = 16'hFFFF;
  localparam logic [15:0] SBTC_COUNT_ZERO = 16'h0000;
  localparam logic [7:0] SBTC_BYTE_ZERO = 8'h00;
  localparam logic [2:0] SBTC_PS_ZERO = 3'h0;
  localparam logic [2:0] SBTC_PS_ONE = 3'h1;
  // Instruction cycle is a quarter of the oscillator rate
  localparam logic [1:0] SBTC_QUARTER_LAST = 2'h3;
  // ********************************************************************
  // Power-managed modes
  // ********************************************************************
  typedef enum logic [1:0] {
    SBTC_PM_PRI = 2'b00,
    SBTC_PM_SEC_RUN = 2'b01,
    SBTC_PM_SEC_IDLE = 2'b10
  } sbtc_pm_t;
endpackage : sbtc_pkg
`default_nettype wire

// file: sbtc_timer.sv
// Sixteen-bit timer/counter with APB register slave.
`default_nettype none
// How it works
// - Timer, sync counter, async counter modes
// - Source zero counts each instruction cycle
// - Source one counts external pin rising edges, oscillator pin edges when oscillator enabled
// - Enabled timer forces pins input, reads zero
// - Wide mode: low read snapshots high byte
// - Wide mode: high write buffered, loaded later
// - Wide mode: high byte only via buffer
// - Low write clears prescaler, high does not
// - Oscillator enable bit starts crystal oscillator
// - Oscillator keeps running in power modes
// - Clock select 01 with oscillator enable set enters secondary run
// - Sleep without idle enters secondary idle
// - Status flag shows oscillator clocks system
// - Low-power bit lowers oscillator power
// - Wrap sets overflow flag bit 0
// - Interrupt only while enable bit set
// - Compare special mode trigger resets counter
// - Second compare trigger starts conversion
// - Trigger reset only in synchronous modes
// - Software write beats trigger reset
// - Trigger reset never sets overflow flag
// - Counts only while run bit set
module sbtc_timer
  import sbtc_pkg::*;
#(
  parameter int PS_BITS = 3
) (
  input wire logic CORE_CLK,
  input wire logic SRST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic EXT_CLK_IN,
  input wire logic OSC_CLK_IN,
  input wire logic CMP1_TRIG,
  input wire logic CMP2_TRIG,
  input wire logic ADC_ENABLED,
  input wire logic SLEEP_EXEC,
  input wire logic [1:0] PORT_DIR_IN,
  output logic [1:0] PIN_OUT_EN,
  output logic OSC_ENABLE,
  output logic OSC_LOW_POWER,
  output logic SYS_CLK_FROM_OSC,
  output logic CPU_IDLE,
  output logic ADC_START,
  output logic OVF_IRQ
);
  // ********************************************************************
  // Elaboration checks
  // ********************************************************************
  if (PS_BITS != 3) begin : g_bad_ps
    $error("PS_BITS must be 3");
  end
  // ********************************************************************
  // Registers and bus decode
  // ********************************************************************
  logic run_bit, source_select_bit, nsync_bit, osc_enable_bit, wide_access_bit;
  logic low_power_config_bit, idle_enable_bit, overflow_flag, overflow_irq_enable;
  logic [1:0] prescale_sel, system_clock_select;
  logic [3:0] compare_one_mode, compare_two_mode;
  logic [7:0] count_low_byte, count_high_byte, high_buffer;
  logic [2:0] prescale_count;
  logic [1:0] quarter;
  logic ext_q, osc_q;
  sbtc_pm_t pm_mode;
  logic access, wr, rd, wr_low, wr_high, rd_low, mapped;
  logic tick, edge_in, ps_done, wrap, trig;
  logic [2:0] ps_limit;
  logic [15:0] count_now;

  assign access = PSEL && PENABLE && PREADY;
  assign wr = access && PWRITE;
  assign rd = access && !PWRITE;
  assign wr_low = wr && (PADDR == SBTC_ADDR_LOW);
  assign wr_high = wr && (PADDR == SBTC_ADDR_HIGH);
  assign rd_low = rd && (PADDR == SBTC_ADDR_LOW);
  assign mapped = (PADDR == SBTC_ADDR_CTRL) || (PADDR == SBTC_ADDR_LOW) ||
                  (PADDR == SBTC_ADDR_HIGH) || (PADDR == SBTC_ADDR_FLAG) ||
                  (PADDR == SBTC_ADDR_IEN) || (PADDR == SBTC_ADDR_OSC) ||
                  (PADDR == SBTC_ADDR_CMP) || (PADDR == SBTC_ADDR_PORT);
  assign count_now = {count_high_byte, count_low_byte};

  // Ready one cycle after setup: every access has one wait-free access phase
  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      PREADY <= 1'b0;
    end else begin
      PREADY <= PSEL && !PENABLE;
    end
  end

  // Control register writes
  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      run_bit <= 1'b0;
      source_select_bit <= 1'b0;
      nsync_bit <= 1'b0;
      osc_enable_bit <= 1'b0;
      prescale_sel <= 2'h0;
      wide_access_bit <= 1'b0;
      low_power_config_bit <= 1'b0; // Higher power is the default
    end else if (wr && PADDR == SBTC_ADDR_CTRL) begin
      run_bit <= PWDATA[SBTC_RUN_BIT];
      source_select_bit <= PWDATA[SBTC_SRC_BIT];
      nsync_bit <= PWDATA[SBTC_NSYNC_BIT];
      osc_enable_bit <= PWDATA[SBTC_OSCEN_BIT];
      prescale_sel <= PWDATA[SBTC_PS_LO +: 2];
      wide_access_bit <= PWDATA[SBTC_WIDE_BIT];
      low_power_config_bit <= PWDATA[SBTC_LP_BIT];
    end
  end

  // Oscillator control, enable and compare mode registers
  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      system_clock_select <= 2'h0;
      idle_enable_bit <= 1'b0;
      overflow_irq_enable <= 1'b0;
      compare_one_mode <= 4'h0;
      compare_two_mode <= 4'h0;
    end else begin
      if (wr && PADDR == SBTC_ADDR_OSC) begin
        system_clock_select <= PWDATA[1:0];
        idle_enable_bit <= PWDATA[SBTC_IDLE_ENABLE_BIT_BIT];
      end
      if (wr && PADDR == SBTC_ADDR_IEN) begin
        overflow_irq_enable <= PWDATA[0];
      end
      if (wr && PADDR == SBTC_ADDR_CMP) begin
        compare_one_mode <= PWDATA[3:0];
        compare_two_mode <= PWDATA[SBTC_CMP2_LO +: 4];
      end
    end
  end

  // ********************************************************************
  // Clock sources and prescaler
  // ********************************************************************
  // Input samplers; inputs are already synchronous, only edges are found
  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      ext_q <= 1'b0;
      osc_q <= 1'b0;
      quarter <= 2'h0;
    end else begin
      ext_q <= EXT_CLK_IN;
      osc_q <= OSC_CLK_IN;
      quarter <= quarter + 2'h1;
    end
  end

  // Oscillator pin wins over the external pin when enabled
  assign edge_in = osc_enable_bit ? (OSC_CLK_IN && !osc_q) : (EXT_CLK_IN && !ext_q);
  assign tick = run_bit && (source_select_bit ? edge_in : (quarter == SBTC_QUARTER_LAST));
  assign ps_limit = (SBTC_PS_ONE << prescale_sel) - SBTC_PS_ONE;
  assign ps_done = tick && (prescale_count == ps_limit);
  assign wrap = ps_done && (count_now == SBTC_COUNT_MAX);
  // Async mode may miss the trigger; here it is simply not honoured
  assign trig = !(source_select_bit && nsync_bit) &&
                ((CMP1_TRIG && compare_one_mode == SBTC_CMP_SPECIAL) ||
                 (CMP2_TRIG && compare_two_mode == SBTC_CMP_SPECIAL));

  // Prescaler: cleared by low-byte writes only
  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      prescale_count <= SBTC_PS_ZERO;
    end else if (wr_low) begin
      prescale_count <= SBTC_PS_ZERO;
    end else if (ps_done) begin
      prescale_count <= SBTC_PS_ZERO;
    end else if (tick) begin
      prescale_count <= prescale_count + SBTC_PS_ONE;
    end
  end

  // ********************************************************************
  // Counter and high-byte buffer
  // ********************************************************************
  // Write beats trigger; trigger beats counting
  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      count_low_byte <= SBTC_BYTE_ZERO;
      count_high_byte <= SBTC_BYTE_ZERO;
    end else if (wr_low || wr_high) begin
      if (wr_low) begin
        count_low_byte <= PWDATA[7:0];
        if (wide_access_bit) begin
          count_high_byte <= high_buffer;
        end
      end
      if (wr_high && !wide_access_bit) begin
        count_high_byte <= PWDATA[7:0];
      end
    end else if (trig) begin
      count_low_byte <= SBTC_BYTE_ZERO;
      count_high_byte <= SBTC_BYTE_ZERO;
    end else if (ps_done) begin
      {count_high_byte, count_low_byte} <= count_now + 16'h0001;
    end
  end

  // Buffer takes high writes and low-read snapshots
  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      high_buffer <= SBTC_BYTE_ZERO;
    end else if (wide_access_bit && wr_high) begin
      high_buffer <= PWDATA[7:0];
    end else if (wide_access_bit && rd_low) begin
      high_buffer <= count_high_byte;
    end
  end

  // Overflow flag: set beats software clear; trigger never sets it
  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      overflow_flag <= 1'b0;
    end else if (wrap && !trig && !(wr_low || wr_high)) begin
      overflow_flag <= 1'b1;
    end else if (wr && PADDR == SBTC_ADDR_FLAG) begin
      overflow_flag <= PWDATA[0];
    end
  end

  // ********************************************************************
  // Power modes and clock status
  // ********************************************************************
  // Sleep while on oscillator without idle enable goes to secondary idle
  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      pm_mode <= SBTC_PM_PRI;
    end else begin
      case (pm_mode)
        SBTC_PM_PRI: begin
          if (system_clock_select == SBTC_SCS_SEC && osc_enable_bit) begin
            pm_mode <= SBTC_PM_SEC_RUN;
          end
        end
        SBTC_PM_SEC_RUN: begin
          if (system_clock_select != SBTC_SCS_SEC || !osc_enable_bit) begin
            pm_mode <= SBTC_PM_PRI;
          end else if (SLEEP_EXEC && !idle_enable_bit) begin
            pm_mode <= SBTC_PM_SEC_IDLE;
          end
        end
        SBTC_PM_SEC_IDLE: begin
          if (!SLEEP_EXEC) begin
            pm_mode <= SBTC_PM_SEC_RUN;
          end
        end
        default: pm_mode <= SBTC_PM_PRI;
      endcase
    end
  end

  // Registered outputs; oscillator enable ignores power mode
  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      OSC_ENABLE <= 1'b0;
      OSC_LOW_POWER <= 1'b0;
      SYS_CLK_FROM_OSC <= 1'b0;
      CPU_IDLE <= 1'b0;
      ADC_START <= 1'b0;
      OVF_IRQ <= 1'b0;
      PIN_OUT_EN <= 2'h0;
    end else begin
      OSC_ENABLE <= osc_enable_bit;
      OSC_LOW_POWER <= low_power_config_bit;
      SYS_CLK_FROM_OSC <= (pm_mode != SBTC_PM_PRI);
      CPU_IDLE <= (pm_mode == SBTC_PM_SEC_IDLE);
      ADC_START <= CMP2_TRIG && compare_two_mode == SBTC_CMP_SPECIAL && ADC_ENABLED;
      OVF_IRQ <= (overflow_flag || (wrap && !trig && !(wr_low || wr_high))) &&
                 overflow_irq_enable;
      PIN_OUT_EN <= run_bit ? 2'h0 : ~PORT_DIR_IN;
    end
  end

  // ********************************************************************
  // Read data
  // ********************************************************************
  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      PRDATA <= 32'h0000_0000;
      PSLVERR <= 1'b0;
    end else begin
      PRDATA <= 32'h0000_0000;
      PSLVERR <= PSEL && !PENABLE && !mapped;
      if (PSEL && !PENABLE && !PWRITE) begin
        case (PADDR)
          SBTC_ADDR_CTRL: PRDATA[8:0] <= {low_power_config_bit, wide_access_bit,
              (pm_mode != SBTC_PM_PRI), prescale_sel, osc_enable_bit, nsync_bit,
              source_select_bit, run_bit};
          SBTC_ADDR_LOW: PRDATA[7:0] <= count_low_byte;
          SBTC_ADDR_HIGH: PRDATA[7:0] <= wide_access_bit ? high_buffer
                                                         : count_high_byte;
          SBTC_ADDR_FLAG: PRDATA[0] <= overflow_flag;
          SBTC_ADDR_IEN: PRDATA[0] <= overflow_irq_enable;
          SBTC_ADDR_OSC: PRDATA[7:0] <= {idle_enable_bit, 5'h00, system_clock_select};
          SBTC_ADDR_CMP: PRDATA[7:0] <= {compare_two_mode, compare_one_mode};
          SBTC_ADDR_PORT: PRDATA[1:0] <= run_bit ? 2'h0 : PORT_DIR_IN;
          default: PRDATA <= 32'h0000_0000;
        endcase
      end
    end
  end

  // ********************************************************************
  // Checks
  // ********************************************************************
  pins_input_a: assert property (@(posedge CORE_CLK) disable iff (SRST)
    run_bit |=> PIN_OUT_EN == 2'h0) else $error("pins driven while enabled");
  stop_hold_a: assert property (@(posedge CORE_CLK) disable iff (SRST)
    !run_bit && !wr && !trig |=> $stable(count_now)) else $error("count moved");
  wrap_flag_a: assert property (@(posedge CORE_CLK) disable iff (SRST)
    wrap && !trig && !wr |=> overflow_flag && count_now == SBTC_COUNT_ZERO)
    else $error("wrap lost");
  trig_reset_a: assert property (@(posedge CORE_CLK) disable iff (SRST)
    trig && !wr_low && !wr_high |=> count_now == SBTC_COUNT_ZERO)
    else $error("trigger no reset");
  write_wins_a: assert property (@(posedge CORE_CLK) disable iff (SRST)
    trig && wr_low |=> count_low_byte == $past(PWDATA[7:0]))
    else $error("write lost to trigger");
  trig_noflag_a: assert property (@(posedge CORE_CLK) disable iff (SRST)
    trig && !overflow_flag && !wr |=> !overflow_flag) else $error("trig set flag");
  snap_high_a: assert property (@(posedge CORE_CLK) disable iff (SRST)
    wide_access_bit && rd_low |=> high_buffer == $past(count_high_byte))
    else $error("no snapshot");
  irq_gate_a: assert property (@(posedge CORE_CLK) disable iff (SRST)
    !overflow_irq_enable |=> !OVF_IRQ) else $error("irq while masked");
  ps_clear_a: assert property (@(posedge CORE_CLK) disable iff (SRST)
    wr_low |=> prescale_count == SBTC_PS_ZERO) else $error("prescaler kept");
  status_a: assert property (@(posedge CORE_CLK) disable iff (SRST)
    pm_mode == SBTC_PM_PRI ##1 pm_mode == SBTC_PM_PRI |-> !SYS_CLK_FROM_OSC)
    else $error("status wrong");
endmodule : sbtc_timer
`default_nettype wire

// file: tb_sbtc_timer.sv
// Self-checking bench for the sixteen-bit timer/counter.
`default_nettype none
module tb_sbtc_timer;
  import sbtc_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic CORE_CLK = 1'b0;
  logic SRST = 1'b1;
  logic PSEL = 1'b0;
  logic PENABLE = 1'b0;
  logic PWRITE = 1'b0;
  logic [7:0] PADDR = 8'h00;
  logic [31:0] PWDATA = 32'h0;
  logic ADC_ENABLED = 1'b0;
  logic SLEEP_EXEC = 1'b0;
  logic [1:0] PORT_DIR_IN = 2'h3;
  logic [31:0] PRDATA;
  logic [1:0] PIN_OUT_EN;
  logic PREADY, PSLVERR, OSC_ENABLE, OSC_LOW_POWER, SYS_CLK_FROM_OSC, CPU_IDLE, ADC_START, OVF_IRQ;
  wire logic EXT_CLK_IN, OSC_CLK_IN, CMP1_TRIG, CMP2_TRIG;
  int bad_count = 0;
  int num_checks = 0;
  int adc_seen = 0;
  logic [31:0] rv;
  logic [31:0] keep;
  logic ev;
  sbtc_timer u_sbtc_timer (.CORE_CLK(CORE_CLK), .SRST(SRST), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
    .PSLVERR(PSLVERR), .EXT_CLK_IN(EXT_CLK_IN), .OSC_CLK_IN(OSC_CLK_IN),
    .CMP1_TRIG(CMP1_TRIG), .CMP2_TRIG(CMP2_TRIG), .ADC_ENABLED(ADC_ENABLED),
    .SLEEP_EXEC(SLEEP_EXEC), .PORT_DIR_IN(PORT_DIR_IN), .PIN_OUT_EN(PIN_OUT_EN),
    .OSC_ENABLE(OSC_ENABLE), .OSC_LOW_POWER(OSC_LOW_POWER),
    .SYS_CLK_FROM_OSC(SYS_CLK_FROM_OSC), .CPU_IDLE(CPU_IDLE), .ADC_START(ADC_START),
    .OVF_IRQ(OVF_IRQ));
  sbtc_far_model u_sbtc_far_model (.clk(CORE_CLK), .ext_clk(EXT_CLK_IN),
    .osc_clk(OSC_CLK_IN), .cmp1_trig(CMP1_TRIG), .cmp2_trig(CMP2_TRIG));
  // 50 MHz core clock
  always #10 CORE_CLK = ~CORE_CLK;
  // Count conversion starts, a one-cycle pulse is easy to miss otherwise
  always @(posedge CORE_CLK) begin
    if (ADC_START === 1'b1) adc_seen <= adc_seen + 1;
  end
  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task automatic test_done();
    $display("Checks %0d, mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Counts that depend on tick phase are judged against a window
  task automatic chk_rng(input logic [31:0] got, input logic [31:0] lo, input logic [31:0] hi);
    num_checks++;
    if ((got >= lo && got <= hi) !== 1'b1) begin
      bad_count++;
      $display("[FAIL] t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
    end
  endtask
  // One APB transfer; request held until PREADY is seen high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge CORE_CLK);
    PSEL <= 1'b1;
    PENABLE <= 1'b0;
    PWRITE <= wr;
    PADDR <= a;
    PWDATA <= d;
    @(posedge CORE_CLK);
    PENABLE <= 1'b1;
    do begin
      @(posedge CORE_CLK);
      n++;
    end while (PREADY !== 1'b1 && n < 16);
    rv = PRDATA;
    ev = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
    if (PREADY !== 1'b1) begin
      bad_count++;
      test_done();
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rv, exp);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge CORE_CLK);
  endtask
  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    repeat (3) @(posedge CORE_CLK);
    SRST <= 1'b0;
    rd_chk(SBTC_ADDR_CTRL, 32'h0);
    chk(32'(OSC_LOW_POWER), 32'h0);
    wr(SBTC_ADDR_CTRL, 32'h40);
    rd_chk(SBTC_ADDR_CTRL, 32'h0);
    wr(8'h20, 32'hFFFF_FFFF);
    chk(32'(ev), 32'h1);
    rd_chk(8'h20, 32'h0);
    $display("Test registers done");
    PORT_DIR_IN <= 2'h1;
    wr(SBTC_ADDR_HIGH, 32'h0);
    wr(SBTC_ADDR_LOW, 32'h0);
    wr(SBTC_ADDR_CTRL, 32'h1);
    cyc(40);
    chk(32'(PIN_OUT_EN), 32'h0);
    rd_chk(SBTC_ADDR_PORT, 32'h0);
    wr(SBTC_ADDR_CTRL, 32'h0);
    apb(1'b0, SBTC_ADDR_LOW, 32'h0);
    keep = rv;
    chk_rng(rv, 32'd9, 32'd13);
    cyc(20);
    rd_chk(SBTC_ADDR_LOW, keep);
    // Every direction pattern reaches the pins once the timer is stopped
    for (int d = 0; d < 4; d++) begin
      PORT_DIR_IN <= 2'(d);
      cyc(2);
      chk(32'(PIN_OUT_EN), 32'(3 - d));
      rd_chk(SBTC_ADDR_PORT, 32'(d));
    end
    for (int ps = 0; ps < 4; ps++) begin
      wr(SBTC_ADDR_LOW, 32'h0);
      wr(SBTC_ADDR_CTRL, 32'h1 | (ps << 4));
      cyc(64);
      wr(SBTC_ADDR_CTRL, 32'h0);
      apb(1'b0, SBTC_ADDR_LOW, 32'h0);
      chk_rng(rv, 64 / (4 << ps) - 1, 76 / (4 << ps) + 1);
    end
    // Writes spaced under one 1:8 period: low writes hold the count at zero
    wr(SBTC_ADDR_CTRL, 32'h31);
    repeat (6) begin
      cyc(14);
      wr(SBTC_ADDR_LOW, 32'h0);
    end
    rd_chk(SBTC_ADDR_LOW, 32'h0);
    repeat (6) begin
      cyc(14);
      wr(SBTC_ADDR_HIGH, 32'h0);
    end
    wr(SBTC_ADDR_CTRL, 32'h0);
    apb(1'b0, SBTC_ADDR_LOW, 32'h0);
    chk_rng(rv, 32'd2, 32'd4);
    $display("Test timer done");
    wr(SBTC_ADDR_HIGH, 32'hFF);
    wr(SBTC_ADDR_LOW, 32'hF0);
    wr(SBTC_ADDR_CTRL, 32'h1);
    cyc(90);
    wr(SBTC_ADDR_CTRL, 32'h0);
    rd_chk(SBTC_ADDR_FLAG, 32'h1);
    rd_chk(SBTC_ADDR_HIGH, 32'h0);
    chk(32'(OVF_IRQ), 32'h0);
    wr(SBTC_ADDR_IEN, 32'h1);
    cyc(2);
    chk(32'(OVF_IRQ), 32'h1);
    wr(SBTC_ADDR_FLAG, 32'h0);
    cyc(2);
    chk(32'(OVF_IRQ), 32'h0);
    $display("Test overflow done");
    wr(SBTC_ADDR_LOW, 32'h0);
    wr(SBTC_ADDR_CTRL, 32'h3);
    u_sbtc_far_model.pulses(1'b0, 5);
    wr(SBTC_ADDR_CTRL, 32'h7);
    u_sbtc_far_model.pulses(1'b0, 2);
    wr(SBTC_ADDR_CTRL, 32'h0);
    rd_chk(SBTC_ADDR_LOW, 32'h7);
    wr(SBTC_ADDR_LOW, 32'h0);
    wr(SBTC_ADDR_CTRL, 32'hB);
    cyc(10); // start-up wait
    chk(32'(OSC_ENABLE), 32'h1);
    u_sbtc_far_model.pulses(1'b1, 3);
    u_sbtc_far_model.pulses(1'b0, 2);
    wr(SBTC_ADDR_CTRL, 32'h0);
    rd_chk(SBTC_ADDR_LOW, 32'h3);
    $display("Test counter done");
    wr(SBTC_ADDR_CTRL, 32'h80);
    wr(SBTC_ADDR_HIGH, 32'h12);
    rd_chk(SBTC_ADDR_LOW, 32'h3);
    rd_chk(SBTC_ADDR_HIGH, 32'h0);
    wr(SBTC_ADDR_HIGH, 32'h34);
    wr(SBTC_ADDR_LOW, 32'h56);
    rd_chk(SBTC_ADDR_LOW, 32'h56);
    rd_chk(SBTC_ADDR_HIGH, 32'h34);
    wr(SBTC_ADDR_CTRL, 32'h0);
    rd_chk(SBTC_ADDR_HIGH, 32'h34);
    $display("Test wide access done");
    wr(SBTC_ADDR_CMP, 32'h0B);
    u_sbtc_far_model.fire(1);
    rd_chk(SBTC_ADDR_LOW, 32'h0);
    rd_chk(SBTC_ADDR_HIGH, 32'h0);
    wr(SBTC_ADDR_HIGH, 32'h12);
    // Trigger lands on the very edge where the low write takes effect
    fork
      wr(SBTC_ADDR_LOW, 32'h56);
      begin
        cyc(2);
        u_sbtc_far_model.fire(1);
      end
    join
    rd_chk(SBTC_ADDR_LOW, 32'h56);
    rd_chk(SBTC_ADDR_HIGH, 32'h12);
    wr(SBTC_ADDR_CMP, 32'hB0);
    ADC_ENABLED <= 1'b1;
    u_sbtc_far_model.fire(2);
    cyc(3);
    rd_chk(SBTC_ADDR_HIGH, 32'h0);
    chk(adc_seen, 32'h1);
    rd_chk(SBTC_ADDR_FLAG, 32'h0);
    chk(32'(OVF_IRQ), 32'h0);
    ADC_ENABLED <= 1'b0;
    u_sbtc_far_model.fire(2);
    cyc(3);
    chk(adc_seen, 32'h1);
    wr(SBTC_ADDR_LOW, 32'h77);
    wr(SBTC_ADDR_CMP, 32'h0);
    u_sbtc_far_model.fire(1);
    rd_chk(SBTC_ADDR_LOW, 32'h77);
    wr(SBTC_ADDR_CMP, 32'h0B);
    wr(SBTC_ADDR_CTRL, 32'h6);
    u_sbtc_far_model.fire(1);
    rd_chk(SBTC_ADDR_LOW, 32'h77);
    $display("Test trigger done");
    wr(SBTC_ADDR_CTRL, 32'h108);
    cyc(10); // start-up wait
    chk(32'(OSC_LOW_POWER), 32'h1);
    wr(SBTC_ADDR_OSC, 32'h1);
    // Mode moves one edge after the write, the status output one edge later
    cyc(3);
    chk(32'(SYS_CLK_FROM_OSC), 32'h1);
    rd_chk(SBTC_ADDR_CTRL, 32'h148);
    SLEEP_EXEC <= 1'b1;
    cyc(3);
    chk(32'(CPU_IDLE), 32'h1);
    chk(32'(OSC_ENABLE), 32'h1);
    SLEEP_EXEC <= 1'b0;
    cyc(3);
    chk(32'(CPU_IDLE), 32'h0);
    // Idle enable set: sleep must not enter secondary idle
    wr(SBTC_ADDR_OSC, 32'h81);
    SLEEP_EXEC <= 1'b1;
    cyc(3);
    chk(32'(CPU_IDLE), 32'h0);
    chk(32'(SYS_CLK_FROM_OSC), 32'h1);
    SLEEP_EXEC <= 1'b0;
    wr(SBTC_ADDR_OSC, 32'h0);
    cyc(3);
    chk(32'(SYS_CLK_FROM_OSC), 32'h0);
    rd_chk(SBTC_ADDR_CTRL, 32'h108);
    $display("Test power modes done");
    test_done();
  end
endmodule // tb_sbtc_timer
`default_nettype wire
